// [core/counter_unit.sv]
// sixteen bit up/down counter unit with shared high-byte holding register
`timescale 1ns/1ps
`include "counter_unit_map.svh"

// How it works
// - 16-bit up/down counter visible as a low byte and a high byte.
// - high-byte accesses, except compare high reads, reach the shared holding register, not the counter.
// - low-byte read copies the counter's upper byte into the holding register.
// - low-byte write loads holding register plus written byte into counter at once.
// - one holding register for all words, so interleaved accesses corrupt each other.
// - three-bit clock select in control B picks internal or external tick.
// - clock select zero stops the counter.
// - counter is readable and writable with or without ticks.
// - processor write beats clear, increment and decrement in the same cycle.
// - each tick clears, increments or decrements by one per mode.
// - four-bit waveform mode split between control A and control B.
// - ceiling flag at sequence maximum, floor flag at zero.
// - overflow flag set at a mode-dependent point, usable as interrupt source.
// - prescaler runs freely regardless of clock select, shared with another timer.
// - first prescaled count comes 1 to N+1 clocks after enable.
// - prescaler reset restarts the period for every connected timer.
// - counter, compare and capture share one holding register for upper bytes.
// - compare reads return both bytes directly, holding register untouched.
module counter_unit #(
    parameter int PRESCALE_BITS = 10
) (
    input wire logic mclk,
    input wire logic reset,
    input wire counter_unit_pkg::io_request_s io_req,
    output logic [7:0] io_rdata,
    input wire logic ext_clock_pin,
    input wire logic capture_strobe,
    input wire logic peer_prescaler_reset,
    output logic prescaler_reset_pulse,
    output logic [3:0] prescaled_ticks,
    output counter_unit_pkg::counter_status_s status,
    output logic overflow_flag,
    output logic [15:0] compare_value
);
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [7:0] temp_reg;
    logic [7:0] temp_next;
    logic [15:0] compare_reg;
    logic [15:0] capture_reg;
    logic [PRESCALE_BITS-1:0] pre_reg;
    logic ext_prev_reg;
    logic ovf_reg;
    logic [7:0] rdata_reg;
    counter_unit_pkg::count_dir_e dir_reg;
    counter_unit_pkg::count_dir_e dir_next;

    // address decode
    wire sel_ctrl_a = io_req.addr == `IDX_CTRL_A;
    wire sel_ctrl_b = io_req.addr == `IDX_CTRL_B;
    wire sel_cnt_lo = io_req.addr == `IDX_CNT_LO;
    wire sel_cnt_hi = io_req.addr == `IDX_CNT_HI;
    wire sel_cmp_lo = io_req.addr == `IDX_CMP_LO;
    wire sel_cmp_hi = io_req.addr == `IDX_CMP_HI;
    wire sel_cap_lo = io_req.addr == `IDX_CAP_LO;
    wire sel_cap_hi = io_req.addr == `IDX_CAP_HI;
    wire sel_flags = io_req.addr == `IDX_FLAGS;
    wire sel_pre_rst = io_req.addr == `IDX_PRE_RST;
    wire wr_cnt_lo = io_req.wr && sel_cnt_lo;
    wire rd_cnt_lo = io_req.rd && sel_cnt_lo;
    wire wr_cap_lo = io_req.wr && sel_cap_lo;
    wire rd_cap_lo = io_req.rd && sel_cap_lo;
    wire wr_cmp_lo = io_req.wr && sel_cmp_lo;
    wire wr_any_hi = io_req.wr && (sel_cnt_hi || sel_cmp_hi || sel_cap_hi);

    // mode fields
    wire [3:0] waveform_mode_field = {ctrl_b_reg[`CTRL_B_WGM_HI], ctrl_a_reg[`CTRL_A_WGM_LO]};
    wire [2:0] clock_select_field = ctrl_b_reg[`CTRL_B_CS];
    wire top_from_capture = waveform_mode_field == 4'h8 || waveform_mode_field == 4'hA
        || waveform_mode_field == 4'hC || waveform_mode_field == 4'hE;

    // prescaler taps, free running and shared
    wire pre_restart = peer_prescaler_reset || prescaler_reset_pulse;
    wire tap_8 = (pre_reg & `PRE_MASK_8) == `PRE_MASK_8;
    wire tap_64 = (pre_reg & `PRE_MASK_64) == `PRE_MASK_64;
    wire tap_256 = (pre_reg & `PRE_MASK_256) == `PRE_MASK_256;
    wire tap_1024 = (pre_reg & `PRE_MASK_1024) == `PRE_MASK_1024;
    assign prescaled_ticks = {tap_1024, tap_256, tap_64, tap_8};
    assign prescaler_reset_pulse = io_req.wr && sel_pre_rst && io_req.wdata[`PRE_RST_BIT];

    // external source edges
    wire ext_rise = ext_clock_pin && !ext_prev_reg;
    wire ext_fall = !ext_clock_pin && ext_prev_reg;

    logic timer_tick;
    always_comb
    begin
        case (counter_unit_pkg::clock_select_e'(clock_select_field))
            counter_unit_pkg::CS_STOP: timer_tick = 1'b0;
            counter_unit_pkg::CS_DIV1: timer_tick = 1'b1;
            counter_unit_pkg::CS_DIV8: timer_tick = tap_8;
            counter_unit_pkg::CS_DIV64: timer_tick = tap_64;
            counter_unit_pkg::CS_DIV256: timer_tick = tap_256;
            counter_unit_pkg::CS_DIV1024: timer_tick = tap_1024;
            counter_unit_pkg::CS_EXT_FALL: timer_tick = ext_fall;
            counter_unit_pkg::CS_EXT_RISE: timer_tick = ext_rise;
            default: timer_tick = 1'b0;
        endcase
    end

    // ceiling value and sequence kind per mode
    logic [15:0] top_value;
    counter_unit_pkg::sequence_e seq_kind;
    always_comb
    begin
        case (waveform_mode_field)
            4'h1, 4'h5:
            begin
                top_value = `TOP_8BIT;
                seq_kind = (waveform_mode_field == 4'h1) ? counter_unit_pkg::SEQ_DUAL
                    : counter_unit_pkg::SEQ_SINGLE;
            end
            4'h2, 4'h6:
            begin
                top_value = `TOP_9BIT;
                seq_kind = (waveform_mode_field == 4'h2) ? counter_unit_pkg::SEQ_DUAL
                    : counter_unit_pkg::SEQ_SINGLE;
            end
            4'h3, 4'h7:
            begin
                top_value = `TOP_10BIT;
                seq_kind = (waveform_mode_field == 4'h3) ? counter_unit_pkg::SEQ_DUAL
                    : counter_unit_pkg::SEQ_SINGLE;
            end
            4'h4:
            begin
                top_value = compare_reg;
                seq_kind = counter_unit_pkg::SEQ_CTC;
            end
            4'h8, 4'hA:
            begin
                top_value = capture_reg;
                seq_kind = counter_unit_pkg::SEQ_DUAL;
            end
            4'h9, 4'hB:
            begin
                top_value = compare_reg;
                seq_kind = counter_unit_pkg::SEQ_DUAL;
            end
            4'hC:
            begin
                top_value = capture_reg;
                seq_kind = counter_unit_pkg::SEQ_CTC;
            end
            4'hE:
            begin
                top_value = capture_reg;
                seq_kind = counter_unit_pkg::SEQ_SINGLE;
            end
            4'hF:
            begin
                top_value = compare_reg;
                seq_kind = counter_unit_pkg::SEQ_SINGLE;
            end
            default:
            begin
                top_value = `WORD_MAX;
                seq_kind = counter_unit_pkg::SEQ_NORMAL;
            end
        endcase
    end

    wire at_top = count_reg == top_value;
    wire at_count_floor = count_reg == `WORD_ZERO;
    wire dual = seq_kind == counter_unit_pkg::SEQ_DUAL;
    wire going_down = dir_reg == counter_unit_pkg::DIR_DOWN;
    wire clear_now = timer_tick && !dual && seq_kind != counter_unit_pkg::SEQ_NORMAL && at_top;
    wire turn_down = dual && !going_down && at_top;
    wire turn_up = dual && going_down && at_count_floor;
    wire step_down = dual && (going_down ? !turn_up : turn_down);

    // overflow point depends on the sequence
    wire ovf_event = timer_tick && !wr_cnt_lo && (dual ? (at_count_floor && going_down)
        : (seq_kind == counter_unit_pkg::SEQ_SINGLE ? at_top : count_reg == `WORD_MAX));
    wire ovf_clear = io_req.wr && sel_flags && io_req.wdata[`FLAGS_OVF];

    always_comb
    begin
        count_next = count_reg;
        dir_next = dir_reg;
        if (wr_cnt_lo)
        begin
            count_next = {temp_reg, io_req.wdata};
        end
        else if (timer_tick)
        begin
            if (clear_now)
            begin
                count_next = `WORD_ZERO;
            end
            else if (step_down)
            begin
                count_next = count_reg - 16'h0001;
            end
            else
            begin
                count_next = count_reg + 16'h0001;
            end
            if (turn_down)
            begin
                dir_next = counter_unit_pkg::DIR_DOWN;
            end
            else if (turn_up || !dual)
            begin
                dir_next = counter_unit_pkg::DIR_UP;
            end
        end
    end

    // holding register, shared by all words
    always_comb
    begin
        temp_next = temp_reg;
        if (wr_any_hi)
        begin
            temp_next = io_req.wdata;
        end
        else if (rd_cnt_lo)
        begin
            temp_next = count_reg[15:8];
        end
        else if (rd_cap_lo)
        begin
            temp_next = capture_reg[15:8];
        end
    end

    logic [7:0] rdata_next;
    always_comb
    begin
        case (io_req.addr)
            `IDX_CTRL_A: rdata_next = ctrl_a_reg;
            `IDX_CTRL_B: rdata_next = ctrl_b_reg;
            `IDX_CNT_LO: rdata_next = count_reg[7:0];
            `IDX_CNT_HI, `IDX_CAP_HI: rdata_next = temp_reg;
            `IDX_CMP_LO: rdata_next = compare_reg[7:0];
            `IDX_CMP_HI: rdata_next = compare_reg[15:8];
            `IDX_CAP_LO: rdata_next = capture_reg[7:0];
            `IDX_FLAGS: rdata_next = {7'h00, ovf_reg};
            default: rdata_next = `BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pre_reg <= '0;
        end
        else
        begin
            pre_reg <= pre_restart ? '0 : pre_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            count_reg <= `WORD_ZERO;
            dir_reg <= counter_unit_pkg::DIR_UP;
            temp_reg <= `BYTE_ZERO;
            ext_prev_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            dir_reg <= dir_next;
            temp_reg <= temp_next;
            ext_prev_reg <= ext_clock_pin;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_a_reg <= `BYTE_ZERO;
            ctrl_b_reg <= `BYTE_ZERO;
        end
        else if (io_req.wr && sel_ctrl_a)
        begin
            ctrl_a_reg <= io_req.wdata;
        end
        else if (io_req.wr && sel_ctrl_b)
        begin
            ctrl_b_reg <= io_req.wdata;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            compare_reg <= `WORD_ZERO;
            capture_reg <= `WORD_ZERO;
        end
        else
        begin
            if (wr_cmp_lo)
            begin
                compare_reg <= {temp_reg, io_req.wdata};
            end
            if (wr_cap_lo && top_from_capture)
            begin
                capture_reg <= {temp_reg, io_req.wdata};
            end
            else if (capture_strobe && !top_from_capture)
            begin
                capture_reg <= count_reg;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ovf_reg <= 1'b0;
            rdata_reg <= `BYTE_ZERO;
        end
        else
        begin
            ovf_reg <= ovf_event || (ovf_reg && !ovf_clear);
            rdata_reg <= io_req.rd ? rdata_next : rdata_reg;
        end
    end

    assign io_rdata = rdata_reg;
    assign overflow_flag = ovf_reg;
    assign compare_value = compare_reg;
    assign status.count_value = count_reg;
    assign status.at_ceiling = at_top;
    assign status.at_floor = at_count_floor;
    assign status.count_down = going_down;
    assign status.clear = clear_now;
    assign status.tick = timer_tick;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    low_write_load_a: assert property (wr_cnt_lo |=> count_reg == {$past(temp_reg), $past(io_req.wdata)})
        else $error("low-byte write did not load full word");
    low_read_copy_a: assert property (rd_cnt_lo && !wr_any_hi |=> temp_reg == $past(count_reg[15:8]))
        else $error("low-byte read did not copy upper byte");
    high_read_temp_a: assert property (io_req.rd && sel_cnt_hi |=> io_rdata == $past(temp_reg))
        else $error("high-byte read did not return holding register");
    stopped_hold_a: assert property (clock_select_field == 3'h0 && !wr_cnt_lo |=> $stable(count_reg))
        else $error("counter moved with no clock selected");
    step_one_a: assert property (timer_tick && !wr_cnt_lo && !clear_now
        |=> (count_reg - $past(count_reg) == 16'h0001) || ($past(count_reg) - count_reg == 16'h0001))
        else $error("counter step not one");
    write_wins_a: assert property (wr_cnt_lo && timer_tick |=> count_reg[7:0] == $past(io_req.wdata))
        else $error("count overrode processor write");
    ovf_sticky_a: assert property (ovf_event |=> ovf_reg)
        else $error("overflow event lost");
    cmp_read_temp_a: assert property (io_req.rd && (sel_cmp_lo || sel_cmp_hi) && !wr_any_hi
        |=> $stable(temp_reg))
        else $error("compare read disturbed holding register");
    div8_period_a: assert property (clock_select_field == 3'h2 && timer_tick && !pre_restart
        |=> !timer_tick [*7])
        else $error("divide-by-8 tick spacing wrong");
    pre_restart_a: assert property (peer_prescaler_reset |=> pre_reg == '0)
        else $error("prescaler not restarted");

    overflow_seen_c: cover property (ovf_event);
    dual_turn_c: cover property (turn_down ##[1:300] turn_up);
    atomic_write_c: cover property (io_req.wr && sel_cnt_hi ##1 wr_cnt_lo);
endmodule // counter_unit

// [core/counter_unit_map.svh]
// register indices, field positions, reset values and prescaler taps of the counter unit
`ifndef COUNTER_UNIT_MAP_SVH
`define COUNTER_UNIT_MAP_SVH
`define IDX_CTRL_A 4'h0
`define IDX_CTRL_B 4'h1
`define IDX_CNT_LO 4'h2
`define IDX_CNT_HI 4'h3
`define IDX_CMP_LO 4'h4
`define IDX_CMP_HI 4'h5
`define IDX_CAP_LO 4'h6
`define IDX_CAP_HI 4'h7
`define IDX_FLAGS 4'h8
`define IDX_PRE_RST 4'h9
`define CTRL_A_WGM_LO 1:0
`define CTRL_B_CS 2:0
`define CTRL_B_WGM_HI 4:3
`define FLAGS_OVF 0
`define PRE_RST_BIT 0
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define WORD_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define PRE_ZERO 10'h000
`define PRE_ONE 10'h001
`define PRE_MASK_8 10'h007
`define PRE_MASK_64 10'h03F
`define PRE_MASK_256 10'h0FF
`define PRE_MASK_1024 10'h3FF
`endif

// [core/counter_unit_pkg.sv]
// types shared by the counter unit
package counter_unit_pkg;
    typedef enum logic [2:0]
    {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clock_select_e;

    // direction as a two-state machine, gray along up -> down
    typedef enum logic
    {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_e;

    typedef enum logic [1:0]
    {
        SEQ_NORMAL = 2'h0,
        SEQ_SINGLE = 2'h1,
        SEQ_DUAL = 2'h3,
        SEQ_CTC = 2'h2
    } sequence_e;

    // signals handed to the mode decoder and waveform logic
    typedef struct packed
    {
        logic [15:0] count_value;
        logic at_ceiling;
        logic at_floor;
        logic count_down;
        logic clear;
        logic tick;
    } counter_status_s;

    typedef struct packed
    {
        logic [3:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } io_request_s;
endpackage

// [tb/cpu_bus_model.sv]
// processor core model driving the byte-wide register port of the counter unit
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic mclk,
    output counter_unit_pkg::io_request_s io_req,
    input wire logic [7:0] io_rdata
);
    initial io_req = '{addr: 4'hF, rd: 1'b0, wr: 1'b0, wdata: 8'hA5};

    // one strobe cycle, then the bus is released with inverted leftovers
    task automatic access(input logic [3:0] a, input logic r, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge mclk);
        io_req <= '{addr: a, rd: r, wr: ~r, wdata: d};
        @(negedge mclk);
        q = io_rdata;
        io_req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    endtask

    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(a, 1'b0, d, q);
    endtask

    task automatic rd8(input logic [3:0] a, output logic [7:0] q);
        access(a, 1'b1, 8'h5A, q);
    endtask

    // high half then low half, one idle bus cycle apart, no other access in between
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr8(lo + 4'h1, v[15:8]);
        wr8(lo, v[7:0]);
    endtask

    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        rd8(lo, v[7:0]);
        rd8(lo + 4'h1, v[15:8]);
    endtask
endmodule // cpu_bus_model

// [tb/test_counter_unit.sv]
// self-checking testbench of the counter unit
`timescale 1ns/1ps
`include "counter_unit_map.svh"
module test_counter_unit;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic ext_clock_pin = 1'b0;
    logic capture_strobe = 1'b0;
    logic peer_prescaler_reset = 1'b0;
    counter_unit_pkg::io_request_s io_req;
    logic [7:0] io_rdata;
    logic prescaler_reset_pulse;
    logic [3:0] prescaled_ticks;
    counter_unit_pkg::counter_status_s status;
    logic overflow_flag;
    logic [15:0] compare_value;
    int err_count = 0;
    int checked = 0;
    int seed = 62466;
    logic [15:0] v, w, top;
    logic [7:0] b;
    int n, k, bad, down, clr, tk;
    int pulses = 0;

    always #4 mclk = ~mclk;

    // prescaler restart requests issued by this unit
    always @(posedge mclk) pulses += prescaler_reset_pulse;

    counter_unit #(.PRESCALE_BITS(10)) i_counter_unit (
        .mclk(mclk), .reset(reset), .io_req(io_req), .io_rdata(io_rdata),
        .ext_clock_pin(ext_clock_pin), .capture_strobe(capture_strobe),
        .peer_prescaler_reset(peer_prescaler_reset),
        .prescaler_reset_pulse(prescaler_reset_pulse), .prescaled_ticks(prescaled_ticks),
        .status(status), .overflow_flag(overflow_flag), .compare_value(compare_value)
    );
    cpu_bus_model i_cpu_bus_model (.mclk(mclk), .io_req(io_req), .io_rdata(io_rdata));

    function automatic logic [15:0] exp_top(input logic [3:0] m);
        case (m)
            4'h1, 4'h5: return `TOP_8BIT;
            4'h2, 4'h6: return `TOP_9BIT;
            4'h3, 4'h7: return `TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: return 16'h0123;
            4'h8, 4'hA, 4'hC, 4'hE: return 16'h0200;
            default: return `WORD_MAX;
        endcase
    endfunction

    function automatic int divisor(input logic [2:0] cs);
        return 8 << (3 * (cs - 3'h2));
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("counts: checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic set_mode(input logic [3:0] m, input logic [2:0] cs);
        i_cpu_bus_model.wr8(`IDX_CTRL_B, {3'h0, m[3:2], 3'h0});
        i_cpu_bus_model.wr8(`IDX_CTRL_A, {6'h00, m[1:0]});
        i_cpu_bus_model.wr8(`IDX_CTRL_B, {3'h0, m[3:2], cs});
    endtask

    task automatic wait_tap(input int t, output int c);
        c = 0;
        while (prescaled_ticks[t] !== 1'b1 && c < 2000)
        begin
            @(negedge mclk);
            c++;
        end
    endtask

    initial
    begin
        #(60000 * 8);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(negedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        check("reset count", 16'h0000, status.count_value);
        check("reset floor", 16'h0001, {15'h0, status.at_floor});
        check("reset flags", 16'h0000, {14'h0, status.at_ceiling, overflow_flag});
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            b = $random(seed);
            i_cpu_bus_model.wr16(`IDX_CNT_LO, v);
            check("count write", v, status.count_value);
            i_cpu_bus_model.wr8(`IDX_CNT_HI, b);
            check("high write", v, status.count_value);
            i_cpu_bus_model.rd16(`IDX_CNT_LO, w);
            check("count read", v, w);
        end
        i_cpu_bus_model.rd8(4'hC, b);
        check("unmapped", 16'h0000, {8'h00, b});
        $display("test word access done");
        i_cpu_bus_model.wr8(`IDX_CNT_HI, 8'h11);
        i_cpu_bus_model.wr8(`IDX_CMP_HI, 8'h22);
        i_cpu_bus_model.wr8(`IDX_CNT_LO, 8'h33);
        check("shared hold", 16'h2233, status.count_value);
        i_cpu_bus_model.wr8(`IDX_CNT_HI, 8'h44);
        i_cpu_bus_model.wr8(`IDX_CNT_LO, 8'h55);
        i_cpu_bus_model.wr8(`IDX_CMP_LO, 8'h66);
        check("hold reuse count", 16'h4455, status.count_value);
        check("hold reuse cmp", 16'h4466, compare_value);
        i_cpu_bus_model.wr8(`IDX_CNT_HI, 8'h77);
        i_cpu_bus_model.rd16(`IDX_CMP_LO, w);
        check("compare read", 16'h4466, w);
        i_cpu_bus_model.wr8(`IDX_CNT_LO, 8'h88);
        check("hold untouched", 16'h7788, status.count_value);
        @(negedge mclk);
        capture_strobe <= 1'b1;
        @(negedge mclk);
        capture_strobe <= 1'b0;
        i_cpu_bus_model.rd16(`IDX_CAP_LO, w);
        check("capture read", 16'h7788, w);
        $display("test holding register done");
        i_cpu_bus_model.wr16(`IDX_CMP_LO, 16'h0123);
        for (int m = 0; m < 16; m++)
        begin
            set_mode(m[3:0], 3'h0);
            i_cpu_bus_model.wr16(`IDX_CAP_LO, 16'h0200);
            i_cpu_bus_model.wr16(`IDX_CNT_LO, 16'h0000);
            i_cpu_bus_model.wr8(`IDX_FLAGS, 8'h01);
            set_mode(m[3:0], 3'h1);
            top = exp_top(m[3:0]);
            bad = 0;
            down = 0;
            clr = 0;
            tk = 0;
            repeat (2100)
            begin
                @(negedge mclk);
                if (status.at_floor !== (status.count_value == 16'h0000)) bad++;
                if (status.at_ceiling !== (status.count_value == top)) bad++;
                if (status.count_value > top) bad++;
                if (status.count_down === 1'b1) down = 1;
                if (status.clear === 1'b1) clr = 1;
                tk += status.tick;
            end
            check("mode clear", {15'h0, m inside {4, 5, 6, 7, 12, 14, 15}}, clr[15:0]);
            check("mode ticks", 16'd2100, tk[15:0]);
            check("mode sequence", 16'h0000, bad[15:0]);
            check("mode direction", {15'h0, m inside {1, 2, 3, 8, 9, 10, 11}}, down[15:0]);
            check("mode overflow", {15'h0, !(m inside {0, 4, 12, 13})}, {15'h0, overflow_flag});
        end
        $display("test modes done");
        set_mode(4'h0, 3'h0);
        i_cpu_bus_model.wr16(`IDX_CNT_LO, 16'hFFFE);
        i_cpu_bus_model.wr8(`IDX_FLAGS, 8'h01);
        check("flag cleared", 16'h0000, {15'h0, overflow_flag});
        i_cpu_bus_model.wr8(`IDX_CTRL_B, 8'h01);
        repeat (4) @(negedge mclk);
        check("wrap overflow", 16'h0001, {15'h0, overflow_flag});
        i_cpu_bus_model.wr16(`IDX_CNT_LO, 16'h1234);
        check("write priority", 16'h1234, status.count_value);
        i_cpu_bus_model.wr8(`IDX_CTRL_B, 8'h00);
        v = status.count_value;
        repeat (20) @(negedge mclk);
        check("stopped", v, status.count_value);
        $display("test overflow done");
        for (int cs = 2; cs < 6; cs++)
        begin
            i_cpu_bus_model.wr16(`IDX_CNT_LO, 16'h0000);
            i_cpu_bus_model.wr8(`IDX_CTRL_B, {5'h00, cs[2:0]});
            n = 0;
            while (status.count_value === 16'h0000 && n < 2000)
            begin
                @(negedge mclk);
                n++;
            end
            check("first count", 16'h0001, {15'h0, n <= divisor(cs[2:0]) + 1});
            i_cpu_bus_model.wr8(`IDX_CTRL_B, 8'h00);
        end
        n = 0;
        repeat (64)
        begin
            @(negedge mclk);
            n += prescaled_ticks[0];
        end
        check("free prescaler", 16'd8, n[15:0]);
        for (int r = 0; r < 2; r++)
        begin
            if (r == 0)
            begin
                @(negedge mclk);
                peer_prescaler_reset <= 1'b1;
                @(negedge mclk);
                peer_prescaler_reset <= 1'b0;
            end
            else
                i_cpu_bus_model.wr8(`IDX_PRE_RST, 8'h01);
            wait_tap(0, n);
            check("restart tap", 16'h0001, {15'h0, n <= 8});
            wait_tap(3, k);
            check("restart phase", 16'd1016, k[15:0]);
        end
        check("reset pulse", 16'h0001, pulses[15:0]);
        $display("test prescaler done");
        for (int cs = 6; cs < 8; cs++)
        begin
            i_cpu_bus_model.wr16(`IDX_CNT_LO, 16'h0000);
            i_cpu_bus_model.wr8(`IDX_CTRL_B, {5'h00, cs[2:0]});
            repeat (5)
            begin
                repeat (4) @(negedge mclk);
                ext_clock_pin <= 1'b1;
                repeat (4) @(negedge mclk);
                ext_clock_pin <= 1'b0;
            end
            repeat (8) @(negedge mclk);
            check("external ticks", 16'h0005, status.count_value);
            i_cpu_bus_model.wr8(`IDX_CTRL_B, 8'h00);
        end
        $display("test external clock done");
        report_and_stop();
    end
endmodule // test_counter_unit
